// [rtl/radio_irq_pkg.sv]
// Purpose: shared constants for the radio interrupt enable block
// Assumes: 32-bit register words, byte addresses on the register bus
// Notes:   event bit positions are common to every event register
package radio_irq_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned BE_W   = DATA_W / 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS          = 12'h100;
	localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE_SET  = 12'h304;
	localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE_CLR  = 12'h308;

	// reset values
	localparam logic [DATA_W-1:0] RST_INTERRUPT_ENABLE = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_EVENT_STATUS     = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_READ_DATA        = 32'h0000_0000;

	// event bit positions
	localparam int unsigned BIT_READY                     = 0;
	localparam int unsigned BIT_ADDRESS                   = 1;
	localparam int unsigned BIT_PAYLOAD                   = 2;
	localparam int unsigned BIT_END                       = 3;
	localparam int unsigned BIT_DISABLED                  = 4;
	localparam int unsigned BIT_DEVICE_ADDRESS_MATCH      = 5;
	localparam int unsigned BIT_DEVICE_ADDRESS_MISS       = 6;
	localparam int unsigned BIT_SIGNAL_STRENGTH_DONE      = 7;
	localparam int unsigned BIT_BIT_COUNTER_MATCH         = 10;
	localparam int unsigned BIT_CHECKSUM_OK               = 12;
	localparam int unsigned BIT_CHECKSUM_ERROR            = 13;
	localparam int unsigned BIT_TRANSMIT_READY            = 21;
	localparam int unsigned BIT_RECEIVE_READY             = 22;
	localparam int unsigned BIT_MAC_HEADER_MATCH          = 23;
	localparam int unsigned BIT_PHYSICAL_LAYER_END        = 27;

	// implemented bits; all others are reserved and read as zero
	localparam logic [DATA_W-1:0] EVENT_BITS_USED = 32'h08e0_34ff;

	typedef enum logic [1:0] {
		REG_NONE       = 2'b00,
		REG_STATUS     = 2'b01,
		REG_ENABLE_SET = 2'b10,
		REG_ENABLE_CLR = 2'b11
	} reg_sel_type;

endpackage

// [rtl/event_flag_bank.sv]
// Purpose: bank of sticky flags with priority of set over clear
// Assumes: set and clear come from logic on the same clock
// Notes:   used for both the event status and the interrupt enables
module event_flag_bank
	import radio_irq_pkg::*;
#(
	parameter int unsigned          WIDTH     = DATA_W,
	parameter logic [WIDTH-1:0]     USED_BITS = '1,
	parameter logic [WIDTH-1:0]     RESET_VAL = '0
)
(
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_nrst,
	// controls
	input  wire logic [WIDTH-1:0] i_set,
	input  wire logic [WIDTH-1:0] i_clear,
	// state
	output logic      [WIDTH-1:0] o_flags
);

	logic [WIDTH-1:0] flags_q;
	logic [WIDTH-1:0] flags_d;

	// a set landing with a clear is kept, so no event is lost
	always_comb
	begin
		flags_d = ((flags_q & ~i_clear) | i_set) & USED_BITS;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			flags_q <= RESET_VAL;
		else
			flags_q <= flags_d;
	end

	assign o_flags = flags_q;

endmodule // event_flag_bank

// [rtl/radio_interrupt_disable_mask.sv]
// Purpose: radio interrupt enable set/clear ports with sticky event status
// Assumes: events are one-cycle pulses from radio logic on i_clk
// Notes:   every access takes two cycles; waitrequest is low in the second
import radio_irq_pkg::*;

// Summary of operation
// - one clears ready..disabled enables; read shows enable
// - one clears address match or miss enable
// - one clears signal strength done enable
// - one clears bit counter match enable
// - one clears checksum ok or error enable
// - one clears transmit or receive ready enable
// - one clears MAC header match enable
// - one clears physical layer end, bit 27
// - set port shares layout, reads same enables
module radio_interrupt_disable_mask
	import radio_irq_pkg::*;
#(
	parameter logic [DATA_W-1:0] USED_BITS = EVENT_BITS_USED
)
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	// register bus, Avalon-MM slave
	input  wire logic [ADDR_W-1:0] i_address,
	input  wire logic              i_read,
	input  wire logic              i_write,
	input  wire logic [DATA_W-1:0] i_writedata,
	input  wire logic [BE_W-1:0]   i_byteenable,
	output logic      [DATA_W-1:0] o_readdata,
	output logic                   o_waitrequest,
	// radio event pulses
	input  wire logic              i_ready_event,
	input  wire logic              i_address_event,
	input  wire logic              i_payload_event,
	input  wire logic              i_end_event,
	input  wire logic              i_disabled_event,
	input  wire logic              i_device_address_match_event,
	input  wire logic              i_device_address_miss_event,
	input  wire logic              i_signal_strength_done_event,
	input  wire logic              i_bit_counter_match_event,
	input  wire logic              i_checksum_ok_event,
	input  wire logic              i_checksum_error_event,
	input  wire logic              i_transmit_ready_event,
	input  wire logic              i_receive_ready_event,
	input  wire logic              i_mac_header_match_event,
	input  wire logic              i_physical_layer_end_event,
	// interrupt
	output logic      [DATA_W-1:0] o_interrupt_enable,
	output logic                   o_irq
);

	// byte lanes to a bit mask
	function automatic logic [DATA_W-1:0] lane_mask(input logic [BE_W-1:0] be);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < BE_W; i++)
			m[i*8 +: 8] = {8{be[i]}};
		return m;
	endfunction

	// word address match, low two bits ignored
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
	endfunction

	logic              done_q;
	logic              access;
	logic              commit;
	reg_sel_type       sel;
	logic [DATA_W-1:0] wr_ones;
	logic [DATA_W-1:0] event_vec;
	logic [DATA_W-1:0] enable_set;
	logic [DATA_W-1:0] enable_clr;
	logic [DATA_W-1:0] status_clr;
	logic [DATA_W-1:0] enable_flags;
	logic [DATA_W-1:0] status_flags;
	logic [DATA_W-1:0] readdata_q;
	logic [DATA_W-1:0] readdata_d;
	logic              irq_q;

	// bus handshake: first cycle waits, second cycle completes
	assign access        = i_read | i_write;
	assign o_waitrequest = access & ~done_q;
	assign commit        = i_write & done_q;

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			done_q <= 1'b0;
		else
			done_q <= access & ~done_q;
	end

	always_comb
	begin
		if (hit(i_address, OFS_EVENT_STATUS))
			sel = REG_STATUS;
		else if (hit(i_address, OFS_INTERRUPT_ENABLE_SET))
			sel = REG_ENABLE_SET;
		else if (hit(i_address, OFS_INTERRUPT_ENABLE_CLR))
			sel = REG_ENABLE_CLR;
		else
			sel = REG_NONE;
	end

	// only bits written as one act; zeros and masked lanes do nothing
	// zero bits ignored
	assign wr_ones = i_writedata & lane_mask(i_byteenable) & USED_BITS;

	always_comb
	begin
		enable_set = '0;
		enable_clr = '0;
		status_clr = '0;
		if (commit)
		begin
			unique case (sel)
				REG_STATUS:     status_clr = wr_ones;
				REG_ENABLE_SET: enable_set = wr_ones;
				REG_ENABLE_CLR: enable_clr = wr_ones;
				REG_NONE:       ;
			endcase
		end
	end

	// event vector in the shared bit layout
	always_comb
	begin
		event_vec = '0;
		event_vec[BIT_READY]                = i_ready_event;
		event_vec[BIT_ADDRESS]              = i_address_event;
		event_vec[BIT_PAYLOAD]              = i_payload_event;
		event_vec[BIT_END]                  = i_end_event;
		event_vec[BIT_DISABLED]             = i_disabled_event;
		event_vec[BIT_DEVICE_ADDRESS_MATCH] = i_device_address_match_event;
		event_vec[BIT_DEVICE_ADDRESS_MISS]  = i_device_address_miss_event;
		event_vec[BIT_SIGNAL_STRENGTH_DONE] = i_signal_strength_done_event;
		event_vec[BIT_BIT_COUNTER_MATCH]    = i_bit_counter_match_event;
		event_vec[BIT_CHECKSUM_OK]          = i_checksum_ok_event;
		event_vec[BIT_CHECKSUM_ERROR]       = i_checksum_error_event;
		event_vec[BIT_TRANSMIT_READY]       = i_transmit_ready_event;
		event_vec[BIT_RECEIVE_READY]        = i_receive_ready_event;
		event_vec[BIT_MAC_HEADER_MATCH]     = i_mac_header_match_event;
		event_vec[BIT_PHYSICAL_LAYER_END]   = i_physical_layer_end_event;
	end

	// set and clear act on one enable bank
	event_flag_bank #(
		.WIDTH     (DATA_W),
		.USED_BITS (USED_BITS),
		.RESET_VAL (RST_INTERRUPT_ENABLE)
	) u_enable (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_set   (enable_set),
		.i_clear (enable_clr),
		.o_flags (enable_flags)
	);

	// events stay pending whether enabled or not
	event_flag_bank #(
		.WIDTH     (DATA_W),
		.USED_BITS (USED_BITS),
		.RESET_VAL (RST_EVENT_STATUS)
	) u_status (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_set   (event_vec),
		.i_clear (status_clr),
		.o_flags (status_flags)
	);

	// read data sampled in the waiting cycle, stands at the completing edge
	always_comb
	begin
		unique case (sel)
			REG_STATUS:     readdata_d = status_flags;
			REG_ENABLE_SET: readdata_d = enable_flags;
			REG_ENABLE_CLR: readdata_d = enable_flags;
			REG_NONE:       readdata_d = RST_READ_DATA;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			readdata_q <= RST_READ_DATA;
		else if (i_read & ~done_q)
			readdata_q <= readdata_d;
	end

	// registered so the line is glitch free; one cycle behind the flags
	// irq needs enable and flag
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			irq_q <= 1'b0;
		else
			irq_q <= |(status_flags & enable_flags);
	end

	assign o_readdata         = readdata_q;
	assign o_interrupt_enable = enable_flags;
	assign o_irq              = irq_q;

endmodule // radio_interrupt_disable_mask

// [verification/radio_irq_monitor.sv]
// Purpose: checker for the radio interrupt enable ports
// Assumes: byte lanes mask which enables a write may touch
// Notes:   one clock domain, off during reset
module radio_irq_monitor
	import radio_irq_pkg::*;
(
	// clock and reset
	input wire logic              i_clk,
	input wire logic              i_nrst,
	// register bus
	input wire logic [ADDR_W-1:0] i_address,
	input wire logic              i_read,
	input wire logic              i_write,
	input wire logic [DATA_W-1:0] i_writedata,
	input wire logic [BE_W-1:0]   i_byteenable,
	input wire logic [DATA_W-1:0] o_readdata,
	input wire logic              o_waitrequest,
	// events and interrupt
	input wire logic              i_ready_event,
	input wire logic [DATA_W-1:0] o_interrupt_enable,
	input wire logic              o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	logic done;
	logic wc;
	logic ws;
	logic [DATA_W-1:0] lanes;
	assign done = !o_waitrequest;
	assign lanes = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
		{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
	assign wc = i_write && done && i_address[11:2] == 10'h0c2;
	assign ws = i_write && done && i_address[11:2] == 10'h0c1;
	a_clr_drops:
	assert property (wc |=> (o_interrupt_enable & $past(i_writedata & lanes)) == '0)
		else $error("enable survived a clear");
	a_set_raises:
	assert property (ws |=> &(o_interrupt_enable
		| ~($past(i_writedata & lanes) & EVENT_BITS_USED)))
		else $error("enable not set");
	a_zero_keeps:
	assert property (wc |=> ((o_interrupt_enable ^ $past(o_interrupt_enable))
		& ~$past(i_writedata & lanes)) == '0)
		else $error("zero bit changed enable");
	a_only_writes:
	assert property (!(i_write && done) |=> $stable(o_interrupt_enable))
		else $error("enable moved without write");
	a_reserved_zero:
	assert property ((o_interrupt_enable & ~EVENT_BITS_USED) == '0)
		else $error("reserved enable bit set");
	a_read_shows:
	assert property (i_read && done
		&& (i_address[11:2] == 10'h0c2 || i_address[11:2] == 10'h0c1)
		|-> o_readdata == o_interrupt_enable)
		else $error("read differs from enables");
	a_irq_cause:
	assert property (o_irq |-> $past(o_interrupt_enable) != '0)
		else $error("irq with no enable");
	a_event_irq:
	// a write landing on the event edge may drop the enable first
	assert property (i_ready_event && o_interrupt_enable[0] && !(i_write && done)
		|-> ##[1:2] o_irq)
		else $error("enabled event gave no irq");
	a_one_wait:
	assert property ($rose(i_read | i_write) |-> o_waitrequest ##1 done)
		else $error("wait state count wrong");
	cover property (wc);
	cover property ($rose(o_irq));
	cover property (ws);
endmodule // radio_irq_monitor

bind radio_interrupt_disable_mask radio_irq_monitor i_radio_irq_monitor (.i_clk, .i_nrst,
	.i_address, .i_read, .i_write, .i_writedata, .i_byteenable, .o_readdata,
	.o_waitrequest, .i_ready_event, .o_interrupt_enable, .o_irq);

// [verification/tb_radio_interrupt_disable_mask.sv]
// Purpose: bench for the radio interrupt enable ports
// Assumes: one wait state per access
// Notes:   events driven from one vector
module tb_radio_interrupt_disable_mask
	import radio_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0;
	logic        nrst = 0;
	logic        rd = 0;
	logic        wr = 0;
	logic [11:0] adr = '0;
	logic [31:0] wd = '0;
	logic [3:0]  be = 4'hf;
	logic [31:0] q;
	logic [31:0] e;
	logic [14:0] ev = '0;
	logic [31:0] rdata;
	logic [31:0] ien;
	logic        wt;
	logic        irq;
	int          fails = 0;
	int          n_checks = 0;
	int          p[15] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 12, 13, 21, 22, 23, 27};

	always #20 clk = ~clk;

	radio_interrupt_disable_mask i_radio_interrupt_disable_mask (
		.i_clk(clk), .i_nrst(nrst), .i_address(adr), .i_read(rd), .i_write(wr),
		.i_writedata(wd), .i_byteenable(be), .o_readdata(rdata), .o_waitrequest(wt),
		.i_ready_event(ev[0]), .i_address_event(ev[1]), .i_payload_event(ev[2]),
		.i_end_event(ev[3]), .i_disabled_event(ev[4]),
		.i_device_address_match_event(ev[5]), .i_device_address_miss_event(ev[6]),
		.i_signal_strength_done_event(ev[7]), .i_bit_counter_match_event(ev[8]),
		.i_checksum_ok_event(ev[9]), .i_checksum_error_event(ev[10]),
		.i_transmit_ready_event(ev[11]), .i_receive_ready_event(ev[12]),
		.i_mac_header_match_event(ev[13]), .i_physical_layer_end_event(ev[14]),
		.o_interrupt_enable(ien), .o_irq(irq));

	task automatic test_done;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x)
		begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, x);
		end
	endtask

	// one access; read data taken at the edge with waitrequest low
	task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wt !== 1'b0 && n < 20);
		q = rdata;
		rd <= 0;
		wr <= 0;
		if (n >= 20)
		begin
			fails++;
			test_done;
		end
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
	endtask

	function automatic logic [31:0] b(input int i);
		return 32'h1 << p[i];
	endfunction

	initial
	begin
		repeat (20) @(posedge clk);
		nrst <= 1;
		acc(12'h308, 0, '0);
		chk(q, 32'h0);
		acc(12'h304, 1, 32'hffff_ffff);
		acc(12'h304, 0, '0);
		chk(q, 32'h08e0_34ff);
		acc(12'h308, 1, 32'h0);
		acc(12'h308, 0, '0);
		chk(q, 32'h08e0_34ff);
		e = 32'h08e0_34ff;
		for (int i = 0; i < 15; i++)
		begin
			acc(12'h308, 1, b(i));
			e &= ~b(i);
			acc(12'h308, 0, '0);
			chk(q, e);
		end
		// unmapped place must neither store nor echo
		acc(12'h200, 1, 32'hffff_ffff);
		acc(12'h200, 0, '0);
		chk(q | ien, 32'h0);
		// byte lanes limit which enables a write touches
		acc(12'h304, 1, 32'hffff_ffff);
		be <= 4'h2;
		acc(12'h308, 1, 32'hffff_ffff);
		be <= 4'hf;
		acc(12'h308, 0, '0);
		chk(q, 32'h08e0_00ff);
		acc(12'h308, 1, 32'hffff_ffff);
		be <= 4'h8;
		acc(12'h304, 1, 32'hffff_ffff);
		be <= 4'hf;
		acc(12'h304, 0, '0);
		chk(q, 32'h0800_0000);
		acc(12'h308, 1, 32'h0800_0000);
		for (int i = 0; i < 15; i++)
		begin
			pulse(i);
			repeat (2) @(posedge clk);
			chk(irq, 32'h0);
			acc(12'h100, 0, '0);
			chk(q, b(i));
			acc(12'h304, 1, b(i));
			repeat (2) @(posedge clk);
			chk(irq, 32'h1);
			acc(12'h308, 1, b(i));
			repeat (2) @(posedge clk);
			chk(irq, 32'h0);
			acc(12'h100, 1, b(i));
			acc(12'h100, 0, '0);
			chk(q, 32'h0);
		end
		acc(12'h304, 1, 32'h1);
		pulse(0);
		repeat (2) @(posedge clk);
		chk(irq, 32'h1);
		@(posedge clk);
		nrst <= 0;
		repeat (2) @(posedge clk);
		nrst <= 1;
		acc(12'h304, 0, '0);
		chk(q, 32'h0);
		chk(irq, 32'h0);
		test_done;
	end
endmodule // tb_radio_interrupt_disable_mask
